// ---- rtl/rail_strobe_assignment.v ----
// strobe assignment registers and strobe sequencer for backup, switch and ldo rails
// assumes an APB master on pclk and a freshness seal level synchronous to pclk
//
// Summary of operation
// - backup rail b strobe code in bits 5-4; 1 strobe1, 2 strobe2, volatile.
// - backup rail a strobe code in bits 1-0, same codes, nonvolatile backed.
// - strobes 1 and 2 run only while the freshness seal flag is zero.
// - after the seal is broken backup rails are never turned off.
// - load switch code in bits 7-4; codes 3h-Ah mean strobes 3-10.
// - linear regulator code in bits 3-0; codes 3h-Ah mean strobes 3-10.
// - backup register bits 7-6 and 3-2 read zero; strobe fields reset zero.
// - backup sequencing register at 0x24, reset 0x00.
// - switch/ldo sequencing register at 0x25, reset 0x73.
// - output pin sequencing register at 0x26, reset 0x03.
// - power-down strobe delays multiply by ten when the factor bit is set.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "rail_strobe_consts.vh"

module rail_strobe_assignment #(
    parameter integer STEP_CYCLES = `STEP_DELAY_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        freshness_seal_flag,
    output wire        backup_rail_a_en,
    output wire        backup_rail_b_en,
    output wire        load_switch_en,
    output wire        linear_reg_en,
    output wire [3:0]  active_strobe,
    output wire        seq_busy
);

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_UP   = 3'b010;
    localparam [2:0] S_DOWN = 3'b100;

    // counts worked out at full width, then cut to the counter
    localparam [31:0] UP_CNT    = STEP_CYCLES - 1;
    localparam [31:0] DOWN_CNT  = STEP_CYCLES * `PD_DELAY_FACTOR - 1;
    localparam [23:0] UP_LOAD   = UP_CNT[23:0];
    localparam [23:0] DOWN_LOAD = DOWN_CNT[23:0];

    reg  [7:0]  backup_seq_reg;
    reg  [7:0]  switch_ldo_seq_reg;
    reg  [7:0]  out_pin_seq_reg;
    reg         unlock_reg;
    reg         factor_reg;
    reg  [31:0] prdata_reg;
    reg         err_reg;
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [3:0]  strobe_reg;
    reg  [3:0]  strobe_next;
    reg  [23:0] wait_reg;
    reg  [23:0] wait_next;
    reg  [31:0] rd_mux;
    reg         rd_hit;

    wire [9:0]  word_idx;
    wire        setup_ph;
    wire        wr_acc;
    wire        wr_unlock;
    wire        wr_ctrl;
    wire        wr_seq_ok;
    wire        start_up;
    wire        start_down;
    wire        fire;
    wire        strobe_exec;
    wire [3:0]  rail_en;
    wire [15:0] rail_code;

    assign word_idx = paddr[11:2];
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_reg;
    assign pslverr  = psel & penable & err_reg;

    assign wr_unlock = wr_acc & (word_idx == `IDX_UNLOCK);
    assign wr_ctrl   = wr_acc & (word_idx == `IDX_SEQ_CTRL);
    assign wr_seq_ok = wr_acc & unlock_reg;

    // read mux and unmapped detection
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (word_idx)
            `IDX_BACKUP_SEQ:     rd_mux[7:0] = backup_seq_reg & `BACKUP_SEQ_WMASK;
            `IDX_SWITCH_LDO_SEQ: rd_mux[7:0] = switch_ldo_seq_reg;
            `IDX_OUT_PIN_SEQ:    rd_mux[7:0] = out_pin_seq_reg;
            `IDX_UNLOCK:         rd_mux[0]   = unlock_reg;
            `IDX_SEQ_CTRL:       rd_mux[`CTRL_FACTOR_BIT] = factor_reg;
            `IDX_SEQ_STATUS:     rd_mux[15:0] = {rail_en, strobe_reg, 1'b0, state_reg, 1'b0,
                                                 freshness_seal_flag, unlock_reg, seq_busy};
            default:             rd_hit = 1'b0;
        endcase
    end

    // read data and error captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            err_reg    <= ~rd_hit;
        end
    end

    // unlock is consumed by the next write of any kind
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= 1'b0;
        end else if (wr_acc) begin
            unlock_reg <= wr_unlock & (pwdata[7:0] == `UNLOCK_KEY);
        end
    end

    // sequencing registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backup_seq_reg     <= `RST_BACKUP_SEQ;
            switch_ldo_seq_reg <= `RST_SWITCH_LDO_SEQ;
            out_pin_seq_reg    <= `RST_OUT_PIN_SEQ;
        end else if (wr_seq_ok) begin
            if (word_idx == `IDX_BACKUP_SEQ) begin
                backup_seq_reg <= pwdata[7:0] & `BACKUP_SEQ_WMASK;
            end
            if (word_idx == `IDX_SWITCH_LDO_SEQ) begin
                switch_ldo_seq_reg <= pwdata[7:0];
            end
            if (word_idx == `IDX_OUT_PIN_SEQ) begin
                out_pin_seq_reg <= pwdata[7:0];
            end
        end
    end

    // control: start pulses and the power-down delay factor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            factor_reg <= 1'b0;
        end else if (wr_ctrl) begin
            factor_reg <= pwdata[`CTRL_FACTOR_BIT];
        end
    end

    assign start_up   = wr_ctrl & pwdata[`CTRL_UP_BIT];
    assign start_down = wr_ctrl & pwdata[`CTRL_DOWN_BIT] & ~pwdata[`CTRL_UP_BIT];

    assign fire        = (state_reg != S_IDLE) & (wait_reg == 24'h00_0000);
    assign strobe_exec = ~((strobe_reg <= `BACKUP_STROBE_HI) & freshness_seal_flag);

    // strobe walker
    always @* begin
        state_next  = state_reg;
        strobe_next = strobe_reg;
        wait_next   = wait_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_up) begin
                    state_next  = S_UP;
                    strobe_next = `FIRST_STROBE;
                    wait_next   = 24'h00_0000;
                end else if (start_down) begin
                    state_next  = S_DOWN;
                    strobe_next = `LAST_STROBE;
                    wait_next   = 24'h00_0000;
                end
            end
            S_UP: begin
                if (wait_reg != 24'h00_0000) begin
                    wait_next = wait_reg - 24'h00_0001;
                end else if (strobe_reg == `LAST_STROBE) begin
                    state_next  = S_IDLE;
                    strobe_next = 4'h0;
                end else begin
                    strobe_next = strobe_reg + 4'h1;
                    wait_next   = UP_LOAD;
                end
            end
            S_DOWN: begin
                if (wait_reg != 24'h00_0000) begin
                    wait_next = wait_reg - 24'h00_0001;
                end else if (strobe_reg == `FIRST_STROBE) begin
                    state_next  = S_IDLE;
                    strobe_next = 4'h0;
                end else begin
                    strobe_next = strobe_reg - 4'h1;
                    wait_next   = factor_reg ? DOWN_LOAD : UP_LOAD;
                end
            end
            default: begin
                state_next  = S_IDLE;
                strobe_next = 4'h0;
                wait_next   = 24'h00_0000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= S_IDLE;
            strobe_reg <= 4'h0;
            wait_reg   <= 24'h00_0000;
        end else begin
            state_reg  <= state_next;
            strobe_reg <= strobe_next;
            wait_reg   <= wait_next;
        end
    end

    assign seq_busy      = (state_reg != S_IDLE);
    assign active_strobe = strobe_reg;

    // per-rail codes: a, b, linear, switch
    assign rail_code[3:0]   = {2'b00, backup_seq_reg[`RAIL_A_LSB +: 2]};
    assign rail_code[7:4]   = {2'b00, backup_seq_reg[`RAIL_B_LSB +: 2]};
    assign rail_code[11:8]  = switch_ldo_seq_reg[`LINEAR_LSB +: 4];
    assign rail_code[15:12] = switch_ldo_seq_reg[`SWITCH_LSB +: 4];

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : rail
            wire [3:0] lo;
            wire [3:0] hi;
            wire [3:0] code;
            wire       match;
            wire       hold;
            reg        en_reg;
            assign lo    = (i < 2) ? `BACKUP_STROBE_LO : `MAIN_STROBE_LO;
            assign hi    = (i < 2) ? `BACKUP_STROBE_HI : `MAIN_STROBE_HI;
            assign code  = rail_code[i*4 +: 4];
            // out-of-range codes never match, leaving the rail unsequenced
            assign match = (code == strobe_reg) & (code >= lo) & (code <= hi);
            assign hold  = (i < 2) & freshness_seal_flag;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_reg <= 1'b0;
                end else if (fire & strobe_exec & match) begin
                    if (state_reg == S_UP) begin
                        en_reg <= 1'b1;
                    end else if (!hold) begin
                        en_reg <= 1'b0;
                    end
                end
            end
            assign rail_en[i] = en_reg;
        end
    endgenerate

    assign backup_rail_a_en = rail_en[0];
    assign backup_rail_b_en = rail_en[1];
    assign linear_reg_en    = rail_en[2];
    assign load_switch_en   = rail_en[3];

endmodule

// ---- common/rail_strobe_consts.vh ----
// constants for the rail strobe assignment block
// assumes a 10 MHz pclk and a 12-bit APB byte address
`ifndef RAIL_STROBE_CONSTS_VH
`define RAIL_STROBE_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_BACKUP_SEQ     10'h024
`define IDX_SWITCH_LDO_SEQ 10'h025
`define IDX_OUT_PIN_SEQ    10'h026
`define IDX_UNLOCK         10'h030
`define IDX_SEQ_CTRL       10'h031
`define IDX_SEQ_STATUS     10'h032

// reset values
`define RST_BACKUP_SEQ     8'h00
`define RST_SWITCH_LDO_SEQ 8'h73
`define RST_OUT_PIN_SEQ    8'h03

// writable bits of the backup sequencing register
`define BACKUP_SEQ_WMASK   8'h33

// field positions
`define RAIL_A_LSB         0
`define RAIL_B_LSB         4
`define LINEAR_LSB         0
`define SWITCH_LSB         4
`define CTRL_UP_BIT        0
`define CTRL_DOWN_BIT      1
`define CTRL_FACTOR_BIT    2

// unlock key; arbitrary value
`define UNLOCK_KEY         8'h7d

// strobe ranges
`define BACKUP_STROBE_LO   4'h1
`define BACKUP_STROBE_HI   4'h2
`define MAIN_STROBE_LO     4'h3
`define MAIN_STROBE_HI     4'ha
`define FIRST_STROBE       4'h1
`define LAST_STROBE        4'ha

// timing
`define CLK_PERIOD_NS      100
`define STEP_DELAY_US      2000
`define STEP_DELAY_CYCLES  ((`STEP_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define PD_DELAY_FACTOR    10

`endif

// ---- test/rail_strobe_chk.sv ----
// port checker for the rail strobe block
// assumes binding onto rail_strobe_assignment
`timescale 1ns/1ps
`include "rail_strobe_consts.vh"
module rail_strobe_chk #(
    parameter integer STEP_CYCLES = 4
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        freshness_seal_flag,
    input wire        backup_rail_a_en,
    input wire        backup_rail_b_en,
    input wire        load_switch_en,
    input wire [3:0]  active_strobe,
    input wire        seq_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [9:0] idx = paddr[11:2];
    wire       acc = psel && penable;
    wire       hit = idx >= `IDX_BACKUP_SEQ && idx <= `IDX_OUT_PIN_SEQ || idx >= `IDX_UNLOCK && idx <= `IDX_SEQ_STATUS;
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_map: assert property (acc |-> pslverr == !hit) else $error("bad error");
    a_rsvd_zero: assert property (acc && !pwrite && idx == `IDX_BACKUP_SEQ |-> (prdata & ~32'h0000_0033) == 0)
        else $error("reserved bits");
    a_idle_strobe: assert property (!seq_busy |-> active_strobe == 0) else $error("idle strobe");
    a_busy_strobe: assert property (seq_busy |-> active_strobe inside {[1:10]}) else $error("strobe range");
    a_seal_keep_a: assert property ($past(freshness_seal_flag) && $past(backup_rail_a_en) |-> backup_rail_a_en)
        else $error("rail a off");
    a_seal_keep_b: assert property ($past(freshness_seal_flag) && $past(backup_rail_b_en) |-> backup_rail_b_en)
        else $error("rail b off");
    a_rail_a_rise: assert property ($rose(backup_rail_a_en) |-> $past(active_strobe) inside {1, 2}
        && !$past(freshness_seal_flag)) else $error("rail a strobe");
    a_switch_rise: assert property ($rose(load_switch_en) |-> $past(active_strobe) inside {[3:10]})
        else $error("switch strobe");
    a_switch_fall: assert property ($fell(load_switch_en) |-> $past(active_strobe) inside {[3:10]})
        else $error("switch release strobe");
    cover property ($rose(seq_busy));
    cover property (pslverr);
    cover property (freshness_seal_flag && backup_rail_a_en && seq_busy);
endmodule
bind rail_strobe_assignment rail_strobe_chk #(.STEP_CYCLES(STEP_CYCLES)) chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .freshness_seal_flag, .backup_rail_a_en, .backup_rail_b_en,
    .load_switch_en, .active_strobe, .seq_busy);

// ---- test/apb_host.sv ----
// host model: apb master with unlock before sequencing writes
// assumes a zero or more wait state apb slave on pclk
`timescale 1ns/1ps
`include "rail_strobe_consts.vh"
module apb_host (
    input  wire        pclk,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr,
    output reg         psel = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite = 1'b0,
    output reg  [11:0] paddr = 12'h000,
    output reg  [31:0] pwdata = 32'h0000_0000
);
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (!pready) @(posedge pclk);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task seq_write(input [11:0] a, input [7:0] d);
        reg [31:0] r;
        reg        e;
        begin
            xfer(1'b1, {`IDX_UNLOCK, 2'b00}, {24'h00_0000, `UNLOCK_KEY}, r, e);
            xfer(1'b1, a, {24'h00_0000, d}, r, e);
        end
    endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the rail strobe block
// assumes host model apb_host and a short strobe step
`timescale 1ns/1ps
`include "rail_strobe_consts.vh"
module tb;
    localparam integer S = 4;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         freshness_seal_flag = 1'b0;
    wire        psel, penable, pwrite, pready, pslverr, seq_busy;
    wire        backup_rail_a_en, backup_rail_b_en, load_switch_en, linear_reg_en;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  active_strobe;
    integer     miscompares = 0;
    integer     n_tests = 0;
    integer     n, i;
    reg  [31:0] seed = 32'hc79c_0dd2;
    reg  [31:0] r;
    reg  [31:0] rv;
    reg         e;
    reg  [7:0]  bk, sw;
    always #50 pclk = ~pclk;
    rail_strobe_assignment #(.STEP_CYCLES(S)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .freshness_seal_flag, .backup_rail_a_en, .backup_rail_b_en, .load_switch_en,
        .linear_reg_en, .active_strobe, .seq_busy);
    apb_host host_u (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    function [31:0] rnd(input integer unused);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    function on(input [3:0] c);
        on = c >= `MAIN_STROBE_LO && c <= `MAIN_STROBE_HI;
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task rd(input [11:0] a);
        host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask
    task go(input [2:0] c, input integer lo, input [3:0] x);
        begin
            host_u.xfer(1'b1, {`IDX_SEQ_CTRL, 2'b00}, {29'h0, c}, r, e);
            n = 0;
            @(posedge pclk);
            while (seq_busy === 1'b1) begin
                n = n + 1;
                @(posedge pclk);
            end
            check(n >= lo && n <= lo + 4, 1);
            check({load_switch_en, linear_reg_en, backup_rail_b_en, backup_rail_a_en}, x);
            $display("sequence %0d done", c);
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #(3000 * 100);
        miscompares = miscompares + 1;
        final_report;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h090);
        check(r, 32'h0000_0000);
        rd(12'h094);
        check(r, 32'h0000_0073);
        rd(12'h098);
        check(r, 32'h0000_0003);
        rd(12'h100);
        check({r[30:0], e}, 32'h0000_0001);
        host_u.xfer(1'b1, 12'h094, 32'h0000_0055, r, e);
        rd(12'h094);
        check(r, 32'h0000_0073);
        for (i = 0; i < 4; i = i + 1) begin
            rv = rnd(0);
            bk = (i == 0) ? 8'hff : rv[7:0];
            sw = rv[15:8];
            host_u.seq_write(12'h090, bk);
            rd(12'h090);
            check(r, {24'h00_0000, bk & 8'h33});
            host_u.seq_write(12'h094, sw);
            rd(12'h094);
            check(r, {24'h00_0000, sw});
            host_u.seq_write(12'h098, rv[23:16]);
            rd(12'h098);
            check(r, {24'h00_0000, rv[23:16]});
        end
        $display("register tests done");
        host_u.seq_write(12'h090, 8'h21);
        rv = rnd(0);
        sw = rv[7:0];
        sw[7:4] = 4'h3 + sw[6:4];
        host_u.seq_write(12'h094, sw);
        go(3'b001, 9 * S, {on(sw[7:4]), on(sw[3:0]), 2'b11});
        @(posedge pclk) freshness_seal_flag <= 1'b1;
        go(3'b110, 90 * S, 4'b0011);
        @(posedge pclk) freshness_seal_flag <= 1'b0;
        go(3'b010, 9 * S, 4'b0000);
        @(posedge pclk) freshness_seal_flag <= 1'b1;
        go(3'b101, 9 * S, {on(sw[7:4]), on(sw[3:0]), 2'b00});
        final_report;
    end
endmodule
